// ---- hw/sdp_pkg.sv ----
package sdp_pkg;
   // ************************************************************
   // register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam logic [7:0] ADDR_MODE_REG_ZERO = 8'h00; // exit mode bit
   localparam logic [7:0] ADDR_MODE_REG_TWO = 8'h04; // self refresh bits
   localparam logic [7:0] ADDR_STATUS = 8'h08; // power state, read only
   localparam logic [7:0] ADDR_BUF_DELAY = 8'h0c; // buffer disable cycles
   // field positions
   localparam int MR0_EXIT_FAST_BIT = 12; // 1 = fast exit, dll on
   localparam int MR2_AUTO_SR_BIT = 6; // automatic self refresh
   localparam int MR2_SR_RANGE_BIT = 7; // extended range
   // reset values
   localparam logic [31:0] MR0_RESET = 32'h0000_0000;
   localparam logic [31:0] MR2_RESET = 32'h0000_0000;
   localparam logic [7:0] BUF_DELAY_RESET = 8'h01;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // dram commands on the pin decode {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'b0111;
   localparam logic [3:0] CMD_ACT = 4'b0011;
   localparam logic [3:0] CMD_PRE = 4'b0010;
   localparam logic [3:0] CMD_REF = 4'b0001;
   // power states
   typedef enum logic [1:0] {SDP_AWAKE, SDP_ACTIVE_PD, SDP_PRECHARGE_PD} sdp_pd_e;
endpackage : sdp_pkg

// ---- hw/sdp_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// configuration bits travelling from the register file to the core
interface sdp_cfg_if;
   logic exit_fast; // mode_reg_zero exit type
   logic auto_sr; // auto_self_refresh_bit
   logic sr_range; // self_refresh_range_bit
   logic [7:0] buf_delay; // buffer_disable_delay in cycles
   sdp_pkg::sdp_pd_e pd_state; // state back to software
   logic dll_on;
   logic sr_ext_ok; // self refresh may run above the normal range
   modport regs (output exit_fast, auto_sr, sr_range, buf_delay,
                 input pd_state, dll_on, sr_ext_ok);
   modport core (input exit_fast, auto_sr, sr_range, buf_delay,
                 output pd_state, dll_on, sr_ext_ok);
endinterface : sdp_cfg_if
`default_nettype wire

// ---- hw/sdp_pd_core.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// power-down state tracking for the dram core
// ************************************************************
module sdp_pd_core
   import sdp_pkg::*;
#(
   parameter int BANKS = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n,
   input wire logic cke_s, // synchronised clock enable
   input wire logic [3:0] cmd_s, // synchronised command
   input wire logic [2:0] ba_s, // bank address
   input wire logic a10_s, // all-bank precharge
   sdp_cfg_if.core cfg,
   output logic buf_en_reg, // input/output buffers enabled
   output logic odt_async_reg // termination in asynchronous mode
);
   // the bank field on the pins is three bits wide, so more banks cannot be told apart
   if (BANKS < 1 || BANKS > 8)
   begin : g_bad_banks
      $error("sdp_pd_core: BANKS out of range");
   end
   logic [BANKS-1:0] open_reg; // per-bank open flags
   logic cke_q; // clock enable at the previous edge
   logic [7:0] bd_cnt_reg; // buffer disable countdown
   sdp_pd_e st_reg;
   function automatic logic is_idle(input logic [3:0] c);
      is_idle = (c == CMD_NOP) || c[3]; // nop or deselect
   endfunction : is_idle
   // bank tracking keeps running while entry proceeds, so pending
   // activations and precharges finish normally [R8]
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         open_reg <= '0;
      else if (cke_q && cmd_s == CMD_ACT)
         open_reg[ba_s[$clog2(BANKS > 1 ? BANKS : 2)-1:0]] <= 1'b1;
      else if (cke_q && cmd_s == CMD_PRE)
      begin
         if (a10_s)
            open_reg <= '0;
         else
            open_reg[ba_s[$clog2(BANKS > 1 ? BANKS : 2)-1:0]] <= 1'b0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         cke_q <= 1'b1;
      else
         cke_q <= cke_s;
   end
   // entry on cke low with nop/des, exit on cke high with nop/des [R6] [R19]
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= SDP_AWAKE;
      else
         case (st_reg)
            SDP_AWAKE:
               if (cke_q && !cke_s && is_idle(cmd_s))
                  st_reg <= (|open_reg) ? SDP_ACTIVE_PD : SDP_PRECHARGE_PD; // [R15]
            default:
               if (cke_s && is_idle(cmd_s))
                  st_reg <= SDP_AWAKE;
               else if (st_reg == SDP_PRECHARGE_PD && |open_reg)
                  st_reg <= SDP_ACTIVE_PD; // late activation completed [R15]
               else if (st_reg == SDP_ACTIVE_PD && !(|open_reg))
                  st_reg <= SDP_PRECHARGE_PD; // late precharge completed [R15]
         endcase
   end
   // buffers go off after the programmed delay, except clock/odt/cke/reset [R12]
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_en_reg <= 1'b1;
         bd_cnt_reg <= '0;
      end
      else if (st_reg == SDP_AWAKE)
      begin
         buf_en_reg <= 1'b1;
         bd_cnt_reg <= cfg.buf_delay;
      end
      else if (bd_cnt_reg != 8'h00)
         bd_cnt_reg <= bd_cnt_reg - 8'h01;
      else
         buf_en_reg <= 1'b0; // [R12]
   end
   // slow-exit precharge power-down: odt asynchronous [R11]
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         odt_async_reg <= 1'b0;
      else
         odt_async_reg <= (st_reg == SDP_PRECHARGE_PD) && !cfg.exit_fast; // [R11]
   end
   // dll off only in slow-exit precharge power-down [R16] [R17] [R18]
   assign cfg.dll_on = !((st_reg == SDP_PRECHARGE_PD) && !cfg.exit_fast);
   assign cfg.pd_state = st_reg;
   // extended self refresh: auto rate [R4] or manual range [R3]
   assign cfg.sr_ext_ok = cfg.auto_sr | cfg.sr_range;
endmodule : sdp_pd_core
`default_nettype wire

// ---- hw/sdp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: refresh doubled above 85C, 32 ms
// R2: no hot self refresh without auto/range
// R3: range bit picks normal or extended range
// R4: auto bit adapts self refresh rate
// R5: auto and range both set illegal
// R6: cke low with nop enters power-down
// R7: no cke low during mrs/read/write
// R8: activate/precharge/refresh complete during entry
// R9: act/pre/ref one clock, mrs tmod
// R10: read/write entry delays by latency
// R11: slow exit makes odt asynchronous
// R12: entry disables buffers except clk/odt/cke/reset
// R13: only nop/des until buffers off
// R14: unlocked dll needs reset after exit
// R15: open bank gives active power-down
// R16: slow exit dll off, fast on
// R17: active power-down keeps dll on
// R18: mode_reg_zero bit 12 selects exit type
// R19: cke high with nop exits
// R20: power-down at most nine refresh intervals
// R21: controller tracks banks and delays
module sdp_top
   import sdp_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cke_i, // clock-enable pin
   input wire logic [3:0] cmd_i, // {cs_n, ras_n, cas_n, we_n}
   input wire logic [2:0] ba_i,
   input wire logic a10_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic buf_en_o, // input/output buffers enabled
   output logic odt_async_o, // termination asynchronous
   output logic dll_on_o // dll running
);
   // ************************************************************
   // reset and pin synchronisers
   // ************************************************************
   logic [1:0] rst_sync; // reset release chain
   logic rst_n;
   logic [5:0] pin_m, pin_s; // two-stage pin capture
   logic [2:0] ba_m, ba_s;
   logic mr0_exit_reg, mr2_auto_reg, mr2_range_reg;
   logic [7:0] buf_delay_reg;
   logic [7:0] aw_addr_reg;
   logic aw_have, w_have;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic buf_en_w, odt_w;
   sdp_cfg_if cfg ();
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];
   // pins come from the controller's clock path, so two flops first
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_m <= {1'b1, CMD_NOP, 1'b0};
         pin_s <= {1'b1, CMD_NOP, 1'b0};
         ba_m <= '0;
         ba_s <= '0;
      end
      else
      begin
         pin_m <= {cke_i, cmd_i, a10_i};
         pin_s <= pin_m;
         ba_m <= ba_i;
         ba_s <= ba_m;
      end
   end
   // ************************************************************
   // axi4-lite write channel: address and data in either order
   // ************************************************************
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         mr0_exit_reg <= MR0_RESET[MR0_EXIT_FAST_BIT];
         mr2_auto_reg <= MR2_RESET[MR2_AUTO_SR_BIT];
         mr2_range_reg <= MR2_RESET[MR2_SR_RANGE_BIT];
         buf_delay_reg <= BUF_DELAY_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (aw_have && w_have && !s_axi_bvalid)
         begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (aw_addr_reg == ADDR_MODE_REG_ZERO)
            begin
               if (w_strb_reg[1])
                  mr0_exit_reg <= w_data_reg[MR0_EXIT_FAST_BIT]; // [R18]
            end
            else if (aw_addr_reg == ADDR_MODE_REG_TWO)
            begin
               // both bits set is the controller's fault; stored as given [R5]
               if (w_strb_reg[0])
               begin
                  mr2_auto_reg <= w_data_reg[MR2_AUTO_SR_BIT]; // [R4]
                  mr2_range_reg <= w_data_reg[MR2_SR_RANGE_BIT]; // [R3]
               end
            end
            else if (aw_addr_reg == ADDR_BUF_DELAY)
            begin
               if (w_strb_reg[0])
                  buf_delay_reg <= w_data_reg[7:0];
            end
            else if (aw_addr_reg != ADDR_STATUS)
               s_axi_bresp <= RESP_SLVERR;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
      end
   end
   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr == ADDR_MODE_REG_ZERO)
               s_axi_rdata[MR0_EXIT_FAST_BIT] <= mr0_exit_reg;
            else if (s_axi_araddr == ADDR_MODE_REG_TWO)
            begin
               s_axi_rdata[MR2_AUTO_SR_BIT] <= mr2_auto_reg;
               s_axi_rdata[MR2_SR_RANGE_BIT] <= mr2_range_reg;
            end
            else if (s_axi_araddr == ADDR_STATUS)
               // state, dll, hot self refresh allowed [R2]
               s_axi_rdata[3:0] <= {cfg.sr_ext_ok, cfg.dll_on, cfg.pd_state};
            else if (s_axi_araddr == ADDR_BUF_DELAY)
               s_axi_rdata[7:0] <= buf_delay_reg;
            else
               s_axi_rresp <= RESP_SLVERR;
         end
      end
   end
   assign cfg.exit_fast = mr0_exit_reg;
   assign cfg.auto_sr = mr2_auto_reg;
   assign cfg.sr_range = mr2_range_reg;
   assign cfg.buf_delay = buf_delay_reg;
   // ************************************************************
   // power-down core
   // ************************************************************
   sdp_pd_core #(.BANKS(8)) u_core (
      .clk_i(clk_i),
      .rst_n(rst_n),
      .cke_s(pin_s[5]),
      .cmd_s(pin_s[4:1]),
      .ba_s(ba_s),
      .a10_s(pin_s[0]),
      .cfg(cfg.core),
      .buf_en_reg(buf_en_w),
      .odt_async_reg(odt_w)
   );
   // outputs re-registered so each comes straight from a flop
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_en_o <= 1'b1;
         odt_async_o <= 1'b0;
         dll_on_o <= 1'b1;
      end
      else
      begin
         buf_en_o <= buf_en_w;
         odt_async_o <= odt_w;
         // taken from the termination flop, so the dll never reads as off
         // a cycle before termination has gone asynchronous [R11] [R16]
         dll_on_o <= !odt_w;
      end
   end
endmodule : sdp_top
`default_nettype wire

// ---- verif/sdp_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// power-down and register bus checks
// ************************************************************
module sdp_top_monitor
   import sdp_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cke_i,
   input wire logic [3:0] cmd_i,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic buf_en_o,
   input wire logic odt_async_o,
   input wire logic dll_on_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // bound covers the pin sync, output lag and the largest buffer delay used
   chk_pd_entry: assert property ($fell(cke_i) && cmd_i == CMD_NOP |-> ##[1:24] !buf_en_o)
      else $error("buffers stayed on after entry");
   chk_pd_exit: assert property ($rose(cke_i) |-> ##[1:12] buf_en_o)
      else $error("buffers not back after exit");
   chk_entry_cause: assert property ($fell(buf_en_o) |-> !$past(cke_i) && !$past(cke_i, 3))
      else $error("buffers dropped without clock enable low");
   chk_dll_odt: assert property (!dll_on_o |-> odt_async_o)
      else $error("dll off with synchronous termination");
   chk_awake_out: assert property (cke_i [*8] |-> buf_en_o && dll_on_o)
      else $error("awake device with buffers or dll off");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   chk_wr_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answered twice");
   // main scenarios reached
   cov_entry: cover property ($fell(buf_en_o));
   cov_dll_off: cover property ($fell(dll_on_o));
   cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : sdp_top_monitor
bind sdp_top sdp_top_monitor i_sdp_top_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
   .cke_i(cke_i), .cmd_i(cmd_i), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .buf_en_o(buf_en_o), .odt_async_o(odt_async_o),
   .dll_on_o(dll_on_o));
`default_nettype wire

// ---- verif/sdp_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// memory controller model driving clock enable and commands
// ************************************************************
module sdp_ctrl_model
   import sdp_pkg::*;
(
   input wire logic clk_i,
   output logic cke_o,
   output logic [3:0] cmd_o,
   output logic [2:0] ba_o,
   output logic a10_o
);
   initial
   begin
      cke_o = 1'b1;
      cmd_o = CMD_NOP;
      ba_o = 3'h0;
      a10_o = 1'b0;
   end
   // deselect: ras/cas/we and bank lines scrambled so no stale command lingers
   task automatic idle();
      @(posedge clk_i);
      cmd_o <= {1'b1, 3'($urandom)};
      ba_o <= 3'($urandom);
   endtask : idle
   // only act, pre or ref; the idle cycle after gives the one-clock entry gap
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic a);
      @(posedge clk_i);
      cmd_o <= c;
      ba_o <= b;
      a10_o <= a;
      idle();
   endtask : issue
   // never entered mid mode set, read or write: the model issues none
   // with no read or write issued, the latency-based entry gaps never bind
   // stays last a few dozen clocks, far inside a halved refresh period
   task automatic enter_pd(input int hold);
      @(posedge clk_i);
      cke_o <= 1'b0;
      cmd_o <= CMD_NOP;
      repeat (hold) idle(); // short stay, far below nine refresh intervals
   endtask : enter_pd
   task automatic exit_pd();
      @(posedge clk_i);
      cke_o <= 1'b1;
      cmd_o <= CMD_NOP;
      repeat (12) idle(); // exit delay before any valid command
   endtask : exit_pd
endmodule : sdp_ctrl_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sdp_pkg::*;
   typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} sdp_exp_s;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cke, a10, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] cmd, wstrb = 0;
   logic [2:0] ba;
   logic [7:0] awaddr = 0, araddr = 0, bdly;
   logic [31:0] wdata = 0, rdata;
   logic awready, wready, bvalid, arready, rvalid, buf_en, odt_async, dll_on;
   logic [1:0] bresp, rresp;
   int n_mismatch = 0;
   int comparisons = 0;
   sdp_exp_s rq[$];
   sdp_exp_s e;
   logic [1:0] bq[$];
   // {fast exit, bank left open, refresh before entry}
   logic [2:0] cases [4] = '{3'b000, 3'b101, 3'b010, 3'b110};
   initial forever #5 clk_i = ~clk_i;
   sdp_top i_sdp_top (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke), .cmd_i(cmd), .ba_i(ba),
      .a10_i(a10), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .buf_en_o(buf_en), .odt_async_o(odt_async), .dll_on_o(dll_on));
   sdp_ctrl_model i_sdp_ctrl_model (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba),
      .a10_o(a10));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // ************************************************************
   // bus master: each channel released at the edge it is taken
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      bit done = 0;
      @(posedge clk_i);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 50 && !done; k++)
      begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) bready <= 1'b0;
         done = bvalid;
      end
      if (!done) begin n_mismatch++; complete_run(); end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                     input logic [1:0] r);
      bit done = 0;
      @(posedge clk_i);
      rq.push_back('{r, x, m});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 50 && !done; k++)
      begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) rready <= 1'b0;
         done = rvalid;
      end
      if (!done) begin n_mismatch++; complete_run(); end
   endtask : rd
   // bounded wait on the buffer enable output
   task automatic wait_buf(input logic v);
      int k;
      for (k = 0; k < 60; k++)
      begin
         @(posedge clk_i);
         if (buf_en === v) break;
      end
      if (k == 60) begin n_mismatch++; complete_run(); end
   endtask : wait_buf
   // watcher: each answer is paired with the oldest note
   always @(posedge clk_i)
   begin
      if (rvalid && rready)
      begin
         e = rq.pop_front();
         check({30'h0, rresp}, {30'h0, e.resp});
         check(rdata & e.mask, e.data);
      end
      if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      logic fast, open;
      logic [1:0] m;
      void'($urandom(93));
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(ADDR_MODE_REG_ZERO, MR0_RESET, 32'hffff_ffff, RESP_OKAY);
      rd(ADDR_MODE_REG_TWO, MR2_RESET, 32'hffff_ffff, RESP_OKAY);
      rd(ADDR_BUF_DELAY, {24'h0, BUF_DELAY_RESET}, 32'h0000_00ff, RESP_OKAY);
      rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_000f, RESP_OKAY);
      rd(8'h10, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
      wr(8'h14, 32'h1234_5678, 4'hf, RESP_SLVERR);
      wr(ADDR_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
      // auto, range and neither; both together is never written
      for (int i = 0; i < 3; i++)
      begin
         m = 2'(i);
         wr(ADDR_MODE_REG_TWO, {24'h0, m, 6'h0}, 4'h1, RESP_OKAY);
         rd(ADDR_MODE_REG_TWO, {24'h0, m, 6'h0}, 32'h0000_00c0, RESP_OKAY);
         rd(ADDR_STATUS, {28'h0, |m, 3'b100}, 32'h0000_000f, RESP_OKAY);
      end
      bdly = 8'($urandom_range(8, 1));
      wr(ADDR_BUF_DELAY, {24'h0, bdly}, 4'h1, RESP_OKAY);
      rd(ADDR_BUF_DELAY, {24'h0, bdly}, 32'h0000_00ff, RESP_OKAY);
      foreach (cases[c])
      begin
         fast = cases[c][2];
         open = cases[c][1];
         wr(ADDR_MODE_REG_ZERO, {19'h0, fast, 12'h0}, 4'h2, RESP_OKAY);
         i_sdp_ctrl_model.issue(CMD_PRE, 3'h0, 1'b1); // every bank closed
         if (open) i_sdp_ctrl_model.issue(CMD_ACT, 3'($urandom), 1'b0);
         if (cases[c][0]) i_sdp_ctrl_model.issue(CMD_REF, 3'h0, 1'b0);
         fork
            i_sdp_ctrl_model.enter_pd(40);
            begin
               wait_buf(1'b0);
               rd(ADDR_STATUS, {29'h1, open | fast, open ? 2'd1 : 2'd2}, 32'h0000_000f,
                  RESP_OKAY);
               check({31'h0, dll_on}, {31'h0, open | fast});
               check({31'h0, odt_async}, {31'h0, !open && !fast});
            end
         join
         fork
            i_sdp_ctrl_model.exit_pd();
            wait_buf(1'b1);
         join
      end
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
